// >>> src/power_mode_timing_regs.v
// Slot period and regulator mode register bank on an AXI4-Lite slave
//
// Contract
// RL1 - Power-down slot code 000..111 selects 31 to 3904 us ascending.
// RL2 - Sleep entry bits 6:4 and exit bits 2:0 select 31 to 3904 us.
// RL3 - Sleep code 011 means 253 us and code 101 means 984 us.
// RL4 - Software writes zero to reserved bits 7 and 3; reads undefined.
// RL5 - Buck mode 00 off, 01 global low power, 10 forced low, 11 normal.
// RL6 - Standalone LDO (source 11) mode 00 is off.
// RL7 - Standalone LDO mode 01 follows the global low-power signal.
// RL8 - Standalone LDO mode 10 is forced low power.
// RL9 - Standalone LDO mode 11 is forced normal.
// RL10 - Sequenced LDO mode 01 on with its sequencer, global low power.
// RL11 - Sequenced LDO mode 10 on with its sequencer, in low power.
// RL12 - Sequenced LDO mode 11 on with its sequencer, in normal mode.
// RL13 - Power-up slot field bits 6:4 uses the same eight periods.
// RL14 - Field reset values load from factory option inputs.
//
// Our own choice: register access over AXI4-Lite.
`include "power_mode_map.vh"

module power_mode_timing_regs (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Factory option values
  input wire [7:0] opt_master_slot_in,
  input wire [7:0] opt_sleep_slot_in,
  input wire [7:0] opt_buck_mode_in,
  input wire [7:0] opt_ldo_mode_in,
  // Live conditions
  input wire global_lowpower_in,
  input wire [7:0] ldo_sequencer_source_in,
  input wire [2:0] power_sequencer_group_in,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // Slot periods in microseconds
  output reg [11:0] powerup_slot_period_out,
  output reg [11:0] powerdown_slot_period_out,
  output reg [11:0] sleep_entry_slot_period_out,
  output reg [11:0] sleep_exit_slot_period_out,
  // Regulator controls
  output reg [3:0] buck_enable_out,
  output reg [3:0] buck_lowpower_out,
  output reg [3:0] ldo_enable_out,
  output reg [3:0] ldo_lowpower_out
);

  // ==========================================
  // Functions

  function [11:0] slot_period_us;
    input [2:0] code;
    begin
      case (code)
        3'h0: slot_period_us = `SLOT_US_0;
        3'h1: slot_period_us = `SLOT_US_1;
        3'h2: slot_period_us = `SLOT_US_2;
        3'h3: slot_period_us = `SLOT_US_3;
        3'h4: slot_period_us = `SLOT_US_4;
        3'h5: slot_period_us = `SLOT_US_5;
        3'h6: slot_period_us = `SLOT_US_6;
        3'h7: slot_period_us = `SLOT_US_7;
        default: slot_period_us = `SLOT_US_0;
      endcase
    end
  endfunction

  // Byte address to register select, 3'h4 when unmapped
  function [2:0] reg_select;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        reg_select = 3'h4;
      end else if (addr[11:2] == {2'h0, `IDX_MASTER_SLOT}) begin
        reg_select = 3'h0;
      end else if (addr[11:2] == {2'h0, `IDX_SLEEP_SLOT}) begin
        reg_select = 3'h1;
      end else if (addr[11:2] == {2'h0, `IDX_BUCK_MODE}) begin
        reg_select = 3'h2;
      end else if (addr[11:2] == {2'h0, `IDX_LDO_MODE_LOW}) begin
        reg_select = 3'h3;
      end else begin
        reg_select = 3'h4;
      end
    end
  endfunction

  // Answer code for a register select
  function [1:0] bus_resp;
    input [2:0] sel;
    begin
      bus_resp = (sel == 3'h4) ? `RESP_SLVERR : `RESP_OKAY;
    end
  endfunction

  // Buck mode field decode
  function buck_enabled;
    input [1:0] field;
    begin
      buck_enabled = (field != `MODE_OFF); // RL5
    end
  endfunction

  function buck_lowpower;
    input [1:0] field;
    input global_lp;
    begin
      buck_lowpower = (field == `MODE_FORCE_LP) ||
        ((field == `MODE_GLOBAL_LP) && global_lp); // RL5
    end
  endfunction

  // ==========================================
  // Register storage

  reg loaded_reg;
  reg [7:0] master_slot_timing_reg;
  reg [7:0] sleep_slot_timing_reg;
  reg [7:0] buck_mode_select_reg;
  reg [7:0] ldo_mode_select_low_reg;

  // ==========================================
  // Write channel capture

  reg aw_held_reg;
  reg [11:0] aw_addr_reg;
  reg w_held_reg;
  reg [7:0] w_data_reg;
  reg w_strb_reg;
  wire do_write;
  wire [2:0] wr_sel;

  assign s_axi_awready_out = loaded_reg & ~aw_held_reg & ~s_axi_bvalid_out;
  assign s_axi_wready_out = loaded_reg & ~w_held_reg & ~s_axi_bvalid_out;
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid_out;
  assign wr_sel = reg_select(aw_addr_reg);

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in[7:0];
        w_strb_reg <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= bus_resp(wr_sel);
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // ==========================================
  // Register file with one-shot factory load

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      loaded_reg <= 1'b0;
      master_slot_timing_reg <= `RST_SLOT;
      sleep_slot_timing_reg <= `RST_SLOT;
      buck_mode_select_reg <= `RST_MODE;
      ldo_mode_select_low_reg <= `RST_MODE;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      master_slot_timing_reg <= opt_master_slot_in & `SLOT_FIELD_MASK; // RL14
      sleep_slot_timing_reg <= opt_sleep_slot_in & `SLOT_FIELD_MASK; // RL14
      buck_mode_select_reg <= opt_buck_mode_in; // RL14
      ldo_mode_select_low_reg <= opt_ldo_mode_in; // RL14
    end else if (do_write && w_strb_reg) begin
      case (wr_sel)
        3'h0: master_slot_timing_reg <= w_data_reg & `SLOT_FIELD_MASK;
        3'h1: sleep_slot_timing_reg <= w_data_reg & `SLOT_FIELD_MASK; // RL4
        3'h2: buck_mode_select_reg <= w_data_reg;
        3'h3: ldo_mode_select_low_reg <= w_data_reg;
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // Read channel

  wire [2:0] rd_sel;
  reg [7:0] rd_value;

  assign s_axi_arready_out = loaded_reg & ~s_axi_rvalid_out;
  assign rd_sel = reg_select(s_axi_araddr_in);

  always @* begin
    case (rd_sel)
      3'h0: rd_value = master_slot_timing_reg;
      3'h1: rd_value = sleep_slot_timing_reg;
      3'h2: rd_value = buck_mode_select_reg;
      3'h3: rd_value = ldo_mode_select_low_reg;
      default: rd_value = 8'h00;
    endcase
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h000000, rd_value};
      s_axi_rresp_out <= bus_resp(rd_sel);
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ==========================================
  // LDO decoders, LDO0 in bits 7:6 down to LDO3 in bits 1:0

  wire [3:0] ldo_enable_next;
  wire [3:0] ldo_lowpower_next;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : ldo_dec
      wire [1:0] mode_field;
      assign mode_field = ldo_mode_select_low_reg[7 - 2 * gi -: 2];
      ldo_mode_decode ldo_mode_decode_i (
        .mode_in(mode_field),
        .source_in(ldo_sequencer_source_in[2 * gi +: 2]),
        .seq_enable_in(power_sequencer_group_in),
        .global_lowpower_in(global_lowpower_in),
        .enable_out(ldo_enable_next[gi]),
        .lowpower_out(ldo_lowpower_next[gi])
      );
    end
  endgenerate

  // ==========================================
  // Registered outputs

  integer i;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      powerup_slot_period_out <= `SLOT_US_0;
      powerdown_slot_period_out <= `SLOT_US_0;
      sleep_entry_slot_period_out <= `SLOT_US_0;
      sleep_exit_slot_period_out <= `SLOT_US_0;
      buck_enable_out <= 4'h0;
      buck_lowpower_out <= 4'h0;
      ldo_enable_out <= 4'h0;
      ldo_lowpower_out <= 4'h0;
    end else begin
      powerup_slot_period_out <=
        slot_period_us(master_slot_timing_reg[`PU_MSB:`PU_LSB]); // RL13
      powerdown_slot_period_out <=
        slot_period_us(master_slot_timing_reg[`PD_MSB:`PD_LSB]); // RL1
      sleep_entry_slot_period_out <=
        slot_period_us(sleep_slot_timing_reg[`ENTRY_MSB:`ENTRY_LSB]); // RL2 RL3
      sleep_exit_slot_period_out <=
        slot_period_us(sleep_slot_timing_reg[`EXIT_MSB:`EXIT_LSB]); // RL2 RL3
      for (i = 0; i < 4; i = i + 1) begin
        buck_enable_out[i] <= buck_enabled(buck_mode_select_reg[2 * i +: 2]); // RL5
        buck_lowpower_out[i] <=
          buck_lowpower(buck_mode_select_reg[2 * i +: 2], global_lowpower_in); // RL5
      end
      ldo_enable_out <= ldo_enable_next;
      ldo_lowpower_out <= ldo_lowpower_next;
    end
  end

endmodule

// >>> src/power_mode_map.vh
// Register indices, field positions and slot periods of the power mode bank
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH

// ==========================================
// Register indices (byte address is four times the index)
`define IDX_MASTER_SLOT 8'h95
`define IDX_SLEEP_SLOT 8'h96
`define IDX_BUCK_MODE 8'h97
`define IDX_LDO_MODE_LOW 8'h98

// ==========================================
// Field positions
`define PU_MSB 6
`define PU_LSB 4
`define PD_MSB 2
`define PD_LSB 0
`define ENTRY_MSB 6
`define ENTRY_LSB 4
`define EXIT_MSB 2
`define EXIT_LSB 0
`define SLOT_FIELD_MASK 8'h77

// ==========================================
// Reset values before the factory option load
`define RST_SLOT 8'h00
`define RST_MODE 8'h00

// ==========================================
// Slot periods in microseconds
`define SLOT_US_0 12'd31
`define SLOT_US_1 12'd63
`define SLOT_US_2 12'd127
`define SLOT_US_3 12'd253
`define SLOT_US_4 12'd508
`define SLOT_US_5 12'd984
`define SLOT_US_6 12'd1936
`define SLOT_US_7 12'd3904

// ==========================================
// Mode codes
`define MODE_OFF 2'h0
`define MODE_GLOBAL_LP 2'h1
`define MODE_FORCE_LP 2'h2
`define MODE_FORCE_NORMAL 2'h3
`define SRC_NONE 2'h3

// ==========================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> src/ldo_mode_decode.v
// Decodes one LDO mode field against its sequencer source selection
`include "power_mode_map.vh"

module ldo_mode_decode (
  // Configuration
  input wire [1:0] mode_in,
  input wire [1:0] source_in,
  // Live conditions
  input wire [2:0] seq_enable_in,
  input wire global_lowpower_in,
  // Regulator control
  output reg enable_out,
  output reg lowpower_out
);

  wire standalone;
  wire [3:0] seq_table;
  wire seq_on;

  // Padded so the source index never leaves the table
  assign seq_table = {1'b0, seq_enable_in};
  assign standalone = (source_in == `SRC_NONE);
  assign seq_on = standalone ? 1'b1 : seq_table[source_in];

  always @* begin
    enable_out = 1'b0;
    lowpower_out = 1'b0;
    case (mode_in)
      `MODE_OFF: begin
        enable_out = 1'b0; // RL6
      end
      `MODE_GLOBAL_LP: begin
        enable_out = seq_on; // RL7 RL10
        lowpower_out = seq_on & global_lowpower_in; // RL7 RL10
      end
      `MODE_FORCE_LP: begin
        enable_out = seq_on; // RL8 RL11
        lowpower_out = seq_on; // RL8 RL11
      end
      `MODE_FORCE_NORMAL: begin
        enable_out = seq_on; // RL9 RL12
        lowpower_out = 1'b0; // RL9 RL12
      end
      default: begin
        enable_out = 1'b0;
      end
    endcase
  end

endmodule

// >>> sim/power_mode_properties.sv
// Port-level checks of the power mode register bank
module power_mode_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Inputs
  input wire logic [7:0] opt_buck_mode_in,
  input wire logic [7:0] ldo_sequencer_source_in,
  input wire logic [2:0] power_sequencer_group_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_rready_in,
  input wire logic s_axi_bready_in,
  // Outputs
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_bvalid_out,
  input wire logic [11:0] powerup_slot_period_out,
  input wire logic [11:0] powerdown_slot_period_out,
  input wire logic [11:0] sleep_entry_slot_period_out,
  input wire logic [11:0] sleep_exit_slot_period_out,
  input wire logic [3:0] buck_enable_out,
  input wire logic [3:0] buck_lowpower_out,
  input wire logic [3:0] ldo_enable_out,
  input wire logic [3:0] ldo_lowpower_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] seq_off;
  logic [3:0] opt_buck_en;
  function automatic logic legal(input logic [11:0] p);
    return p inside {12'h01F, 12'h03F, 12'h07F, 12'h0FD, 12'h1FC, 12'h3D8, 12'h790, 12'hF40};
  endfunction
  // Sequenced LDOs whose sequencer group is off
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      seq_off[n] = ldo_sequencer_source_in[2*n+:2] != 2'h3 &&
        !power_sequencer_group_in[ldo_sequencer_source_in[2*n+:2]];
      opt_buck_en[n] = |opt_buck_mode_in[2*n+:2];
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  powerdown_period_a: assert property (legal(powerdown_slot_period_out))
    else $error("powerdown period off table");
  sleep_periods_a: assert property (
    legal(sleep_entry_slot_period_out) && legal(sleep_exit_slot_period_out))
    else $error("sleep period off table");
  powerup_period_a: assert property (legal(powerup_slot_period_out))
    else $error("powerup period off table");
  buck_lowpower_on_a: assert property ((buck_lowpower_out & ~buck_enable_out) == 4'h0)
    else $error("buck low power while off");
  ldo_lowpower_on_a: assert property ((ldo_lowpower_out & ~ldo_enable_out) == 4'h0)
    else $error("ldo low power while off");
  sequencer_off_a: assert property (($past(seq_off) & ldo_enable_out) == 4'h0)
    else $error("ldo on with sequencer off");
  reset_load_a: assert property ($fell(rst_in) |-> ##2 buck_enable_out == opt_buck_en)
    else $error("buck enables not from option load");
  read_latency_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped");
  write_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write answer dropped");
  read_upper_zero_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
    else $error("read upper bits set");
endmodule

// >>> sim/power_mode_timing_regs_test.sv
// Self-checking bench of the power mode register bank
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module power_mode_timing_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, global_lowpower_in, s_axi_awvalid_in, s_axi_wvalid_in;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic [7:0] opt_master_slot_in, opt_sleep_slot_in, opt_buck_mode_in, opt_ldo_mode_in;
  logic [7:0] ldo_sequencer_source_in;
  logic [2:0] power_sequencer_group_in;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in;
  logic [3:0] s_axi_wstrb_in;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire [11:0] powerup_slot_period_out, powerdown_slot_period_out;
  wire [11:0] sleep_entry_slot_period_out, sleep_exit_slot_period_out;
  wire [3:0] buck_enable_out, buck_lowpower_out, ldo_enable_out, ldo_lowpower_out;
  int errors, n_compared;
  logic [11:0] slot_us [8];
  logic [1:0] rs;
  power_mode_timing_regs power_mode_timing_regs_i (.clk_in, .rst_in, .opt_master_slot_in,
    .opt_sleep_slot_in, .opt_buck_mode_in, .opt_ldo_mode_in, .global_lowpower_in,
    .ldo_sequencer_source_in, .power_sequencer_group_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .powerup_slot_period_out, .powerdown_slot_period_out, .sleep_entry_slot_period_out,
    .sleep_exit_slot_period_out, .buck_enable_out, .buck_lowpower_out, .ldo_enable_out,
    .ldo_lowpower_out);
  // ==========================================
  // Bus tasks
  task automatic give_verdict;
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic reg_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic ta, tw, done;
    done = 1'b0;
    s_axi_awaddr_in <= a;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wdata_in <= {24'h000000, d};
    s_axi_wstrb_in <= s;
    s_axi_wvalid_in <= 1'b1;
    for (int k = 0; k < 40 && !done; k++) begin
      @(negedge clk_in);
      ta = s_axi_awvalid_in & s_axi_awready_out;
      tw = s_axi_wvalid_in & s_axi_wready_out;
      done = s_axi_bvalid_out & s_axi_bready_in;
      r = s_axi_bresp_out;
      @(posedge clk_in);
      if (ta) s_axi_awvalid_in <= 1'b0;
      if (tw) s_axi_wvalid_in <= 1'b0;
      s_axi_bready_in <= s_axi_bvalid_out & !done;
    end
    if (!done) begin errors++; give_verdict(); end
  endtask
  task automatic reg_expect(input logic [11:0] a, input logic [7:0] exp_d,
                            input logic [1:0] exp_r);
    logic ta, done;
    logic [7:0] d;
    logic [1:0] r;
    done = 1'b0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    for (int k = 0; k < 40 && !done; k++) begin
      @(negedge clk_in);
      ta = s_axi_arvalid_in & s_axi_arready_out;
      done = s_axi_rvalid_out & s_axi_rready_in;
      d = s_axi_rdata_out[7:0];
      r = s_axi_rresp_out;
      @(posedge clk_in);
      if (ta) s_axi_arvalid_in <= 1'b0;
      s_axi_rready_in <= s_axi_rvalid_out & !done;
    end
    if (!done) begin errors++; give_verdict(); end
    `CHECK(d, exp_d)
    `CHECK(r, exp_r)
  endtask
  // ==========================================
  // Scenarios
  task automatic check_reset_load;
    reg_expect(12'h254, 8'h77, 2'h0);
    reg_expect(12'h258, 8'h35, 2'h0);
    reg_expect(12'h25C, 8'h1B, 2'h0);
    reg_expect(12'h260, 8'h1B, 2'h0);
    `CHECK(sleep_entry_slot_period_out, slot_us[3])
    `CHECK(sleep_exit_slot_period_out, slot_us[5])
    `CHECK(buck_enable_out, 4'h7)
    `CHECK(buck_lowpower_out, 4'h2)
    `CHECK(ldo_enable_out, 4'hE)
    `CHECK(ldo_lowpower_out, 4'h4)
  endtask
  task automatic check_slot_codes;
    for (int c = 0; c < 8; c++) begin
      reg_write(12'h254, {1'b0, c[2:0], 1'b0, ~c[2:0]}, 4'h1, rs);
      reg_write(12'h258, {1'b0, ~c[2:0], 1'b0, c[2:0]}, 4'h1, rs);
      settle();
      `CHECK(rs, 2'h0)
      `CHECK(powerup_slot_period_out, slot_us[c])
      `CHECK(powerdown_slot_period_out, slot_us[7-c])
      `CHECK(sleep_entry_slot_period_out, slot_us[7-c])
      `CHECK(sleep_exit_slot_period_out, slot_us[c])
    end
  endtask
  task automatic check_mode_codes;
    ldo_sequencer_source_in <= 8'hFF;
    reg_write(12'h25C, 8'hE4, 4'h1, rs);
    reg_write(12'h260, 8'h1B, 4'h1, rs);
    for (int g = 0; g < 2; g++) begin
      global_lowpower_in <= g[0];
      settle();
      `CHECK(buck_enable_out, 4'hE)
      `CHECK(buck_lowpower_out, {2'b01, g[0], 1'b0})
      `CHECK(ldo_enable_out, 4'hE)
      `CHECK(ldo_lowpower_out, {2'b01, g[0], 1'b0})
    end
  endtask
  task automatic check_sequenced;
    ldo_sequencer_source_in <= 8'h24;
    for (int v = 0; v < 16; v++) begin
      power_sequencer_group_in <= v[2:0];
      global_lowpower_in <= v[3];
      settle();
      `CHECK(ldo_enable_out, {v[0], v[2], v[1], 1'b0})
      `CHECK(ldo_lowpower_out, {1'b0, v[2], v[1] & v[3], 1'b0})
    end
  endtask
  task automatic check_refusals;
    reg_write(12'h264, 8'h00, 4'h1, rs);
    `CHECK(rs, 2'h2)
    reg_write(12'h25D, 8'h00, 4'h1, rs);
    `CHECK(rs, 2'h2)
    reg_write(12'h25C, 8'h00, 4'h0, rs);
    `CHECK(rs, 2'h0)
    reg_expect(12'h25C, 8'hE4, 2'h0);
    reg_expect(12'h264, 8'h00, 2'h2);
  endtask
  // ==========================================
  // Clock and main sequence
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    {rst_in, global_lowpower_in, s_axi_awvalid_in, s_axi_wvalid_in} = 4'h8;
    {s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 3'h0;
    {opt_master_slot_in, opt_sleep_slot_in} = 16'hFF35;
    {opt_buck_mode_in, opt_ldo_mode_in, ldo_sequencer_source_in} = 24'h1B1BFF;
    power_sequencer_group_in = 3'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = '0;
    slot_us = '{12'h01F, 12'h03F, 12'h07F, 12'h0FD, 12'h1FC, 12'h3D8, 12'h790, 12'hF40};
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    settle();
    check_reset_load();
    check_slot_codes();
    check_mode_codes();
    check_sequenced();
    check_refusals();
    give_verdict();
  end
endmodule
bind power_mode_timing_regs power_mode_checker power_mode_checker_i (.clk_in, .rst_in,
  .opt_buck_mode_in, .ldo_sequencer_source_in, .power_sequencer_group_in, .s_axi_arvalid_in,
  .s_axi_rready_in, .s_axi_bready_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rdata_out,
  .s_axi_bvalid_out, .powerup_slot_period_out, .powerdown_slot_period_out,
  .sleep_entry_slot_period_out, .sleep_exit_slot_period_out, .buck_enable_out,
  .buck_lowpower_out, .ldo_enable_out, .ldo_lowpower_out);
